//--- rtl/aovc_pkg.sv
// package: constants for the analog output value conditioner
// assumes: 50 MHz module clock, signed 32-bit engineering-unit values
package aovc_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int VAL_W = 32;
	localparam int RATE_W = 32;
	// fault duration codes
	localparam logic [2:0] DUR_FOREVER = 3'h0;
	localparam logic [2:0] DUR_1S = 3'h1;
	localparam logic [2:0] DUR_2S = 3'h2;
	localparam logic [2:0] DUR_5S = 3'h3;
	localparam logic [2:0] DUR_10S = 3'h4;
	// durations in seconds, and cycles derived from them
	localparam int unsigned DUR_1S_SEC = 1;
	localparam int unsigned DUR_2S_SEC = 2;
	localparam int unsigned DUR_5S_SEC = 5;
	localparam int unsigned DUR_10S_SEC = 10;
	localparam logic [31:0] DUR_1S_CYC = 32'(DUR_1S_SEC * CLK_HZ);
	localparam logic [31:0] DUR_2S_CYC = 32'(DUR_2S_SEC * CLK_HZ);
	localparam logic [31:0] DUR_5S_CYC = 32'(DUR_5S_SEC * CLK_HZ);
	localparam logic [31:0] DUR_10S_CYC = 32'(DUR_10S_SEC * CLK_HZ);
	// fault mode codes
	localparam logic FAULT_HOLD = 1'b0;
	localparam logic FAULT_USER = 1'b1;
	// reset values
	localparam logic [VAL_W-1:0] VAL_RST = 32'h0000_0000;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_PROG = 4'h2,
		ST_FLT_USER = 4'h4,
		ST_FLT_FINAL = 4'h8
	} mode_t;
endpackage

//--- rtl/aovc_ramp_step.sv
// ramp step: moves current value toward target by at most step
// assumes: same clock domain, values signed
`timescale 1ns/1ps
`default_nettype none
module aovc_ramp_step (
	input wire logic signed [31:0] i_cur, // present output
	input wire logic signed [31:0] i_tgt, // target value
	input wire logic [31:0] i_step, // largest move this update
	input wire logic i_en, // ramping on
	output logic signed [31:0] o_next // next output
);
	wire logic signed [32:0] diff = 33'(i_tgt) - 33'(i_cur);
	wire logic signed [32:0] step_s = {1'b0, i_step};
	wire logic up_lim = diff > step_s;
	wire logic dn_lim = diff < -step_s;
	wire logic signed [32:0] up_v = 33'(i_cur) + step_s;
	wire logic signed [32:0] dn_v = 33'(i_cur) - step_s;
	// a bounded move stops short of the in-range target so it never overflows range
	assign o_next = !i_en ? i_tgt :
		up_lim ? up_v[31:0] :
		dn_lim ? dn_v[31:0] : i_tgt;
endmodule // aovc_ramp_step
`default_nettype wire

//--- rtl/aovc_channel.sv
// one channel of the analog output value conditioner
// assumes: connection, mode and update strobe come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
module aovc_channel (
	input wire logic i_mclk, // module clock
	input wire logic i_rst_b, // sync reset, active low
	input wire logic i_update, // one-cycle output update strobe
	input wire logic [31:0] i_update_us, // update period in microseconds
	input wire logic i_rpi_tick, // one-cycle update interval strobe
	input wire logic i_conn_ok, // connection to owner alive
	input wire logic i_run_mode, // controller in run mode
	input wire logic signed [31:0] i_data, // requested value
	input wire logic signed [31:0] i_prog_value, // program mode value
	input wire logic i_fault_mode, // 0 hold last, 1 user value
	input wire logic signed [31:0] i_fault_value, // user fault value
	input wire logic [2:0] i_fault_dur, // fault value duration code
	input wire logic signed [31:0] i_final_value, // final fault value
	input wire logic signed [31:0] i_clamp_hi, // high clamp
	input wire logic signed [31:0] i_clamp_lo, // low clamp
	input wire logic i_alarm_dis, // clamp alarms disabled
	input wire logic i_alarm_latch, // clamp alarms latching
	input wire logic i_alarm_unlatch, // one-cycle clear of latched alarms
	input wire logic i_ramp_run_en, // ramp in run mode
	input wire logic i_ramp_on_program_en, // ramp to program value
	input wire logic i_ramp_on_fault_en, // ramp to fault values
	input wire logic [31:0] i_ramp_rate, // max ramp rate, EU per second
	output logic signed [31:0] o_out, // applied output value
	output logic signed [31:0] o_echo, // echoed value to controller
	output logic o_low_clamp_alarm, // low clamp alarm flag
	output logic o_high_clamp_alarm, // high clamp alarm flag
	output logic o_in_fault, // channel in fault behaviour
	output logic o_status_valid // one-cycle, echo and flags refreshed
);
	// --------------------------------------------------------------
	// mode sequencing
	// --------------------------------------------------------------
	aovc_pkg::mode_t mode_reg;
	aovc_pkg::mode_t mode_next;
	logic [31:0] dur_cnt_reg;
	logic [31:0] dur_cnt_next;
	logic hold_reg;
	logic hold_next;
	logic prev_conn_reg;
	logic [31:0] dur_limit;
	wire logic conn_lost = prev_conn_reg && !i_conn_ok;
	wire logic dur_forever = (i_fault_dur == aovc_pkg::DUR_FOREVER);

	always_comb begin
		unique case (i_fault_dur)
			aovc_pkg::DUR_1S: dur_limit = aovc_pkg::DUR_1S_CYC;
			aovc_pkg::DUR_2S: dur_limit = aovc_pkg::DUR_2S_CYC;
			aovc_pkg::DUR_5S: dur_limit = aovc_pkg::DUR_5S_CYC;
			aovc_pkg::DUR_10S: dur_limit = aovc_pkg::DUR_10S_CYC;
			default: dur_limit = 32'h0000_0000;
		endcase
	end

	always_comb begin
		mode_next = mode_reg;
		dur_cnt_next = dur_cnt_reg;
		hold_next = hold_reg;
		unique case (mode_reg)
			aovc_pkg::ST_RUN, aovc_pkg::ST_PROG: begin
				if (conn_lost) begin
					hold_next = (i_fault_mode == aovc_pkg::FAULT_HOLD);
					mode_next = aovc_pkg::ST_FLT_USER;
					dur_cnt_next = 32'h0000_0000;
				end else begin
					mode_next = i_run_mode ? aovc_pkg::ST_RUN : aovc_pkg::ST_PROG;
				end
			end
			aovc_pkg::ST_FLT_USER: begin
				if (i_conn_ok) begin
					hold_next = 1'b0;
					mode_next = i_run_mode ? aovc_pkg::ST_RUN : aovc_pkg::ST_PROG;
				end else if (!hold_reg && !dur_forever) begin
					dur_cnt_next = dur_cnt_reg + 32'h0000_0001;
					if (dur_cnt_next >= dur_limit) begin
						mode_next = aovc_pkg::ST_FLT_FINAL;
					end
				end
			end
			aovc_pkg::ST_FLT_FINAL: begin
				if (i_conn_ok) begin
					mode_next = i_run_mode ? aovc_pkg::ST_RUN : aovc_pkg::ST_PROG;
				end
			end
			default: mode_next = aovc_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			mode_reg <= aovc_pkg::ST_PROG;
			dur_cnt_reg <= 32'h0000_0000;
			hold_reg <= 1'b0;
			prev_conn_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			dur_cnt_reg <= dur_cnt_next;
			hold_reg <= hold_next;
			prev_conn_reg <= i_conn_ok;
		end
	end

	// --------------------------------------------------------------
	// clamping
	// --------------------------------------------------------------
	wire logic over_hi = i_data > i_clamp_hi;
	wire logic under_lo = i_data < i_clamp_lo;
	// clamp limits compared as given; no rescaling
	wire logic signed [31:0] clamped = over_hi ? i_clamp_hi :
		under_lo ? i_clamp_lo : i_data;

	// --------------------------------------------------------------
	// target selection and ramping
	// --------------------------------------------------------------
	wire logic is_run = (mode_reg == aovc_pkg::ST_RUN);
	wire logic is_prog = (mode_reg == aovc_pkg::ST_PROG);
	wire logic is_user = (mode_reg == aovc_pkg::ST_FLT_USER);
	wire logic signed [31:0] target = is_run ? clamped :
		is_prog ? i_prog_value :
		is_user ? (hold_reg ? o_out : i_fault_value) : i_final_value;
	wire logic ramp_en = is_run ? i_ramp_run_en :
		is_prog ? i_ramp_on_program_en :
		hold_reg ? 1'b0 : i_ramp_on_fault_en;
	// rate in EU/s times period in us, scaled down to one update
	wire logic [63:0] step_prod = 64'(i_ramp_rate) * 64'(i_update_us);
	wire logic [63:0] step_div = step_prod / 64'd1000000;
	wire logic [31:0] step = (step_div[63:32] != 32'h0000_0000) ? 32'h7FFF_FFFF :
		(step_div[31:0] == 32'h0000_0000 ? 32'h0000_0001 : step_div[31:0]);
	logic signed [31:0] ramp_out;

	aovc_ramp_step u_ramp (
		.i_cur(o_out),
		.i_tgt(target),
		.i_step(step),
		.i_en(ramp_en),
		.o_next(ramp_out)
	);

	// --------------------------------------------------------------
	// alarms
	// --------------------------------------------------------------
	logic lo_alarm_reg;
	logic hi_alarm_reg;
	wire logic lo_hit = is_run && under_lo && !i_alarm_dis;
	wire logic hi_hit = is_run && over_hi && !i_alarm_dis;
	// latched alarms: set wins over the unlatch strobe
	wire logic lo_alarm_next = lo_hit ? 1'b1 :
		(i_alarm_dis ? 1'b0 : (i_alarm_latch && !i_alarm_unlatch ? lo_alarm_reg : 1'b0));
	wire logic hi_alarm_next = hi_hit ? 1'b1 :
		(i_alarm_dis ? 1'b0 : (i_alarm_latch && !i_alarm_unlatch ? hi_alarm_reg : 1'b0));

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_out <= aovc_pkg::VAL_RST;
			lo_alarm_reg <= 1'b0;
			hi_alarm_reg <= 1'b0;
		end else begin
			if (i_update) begin
				o_out <= ramp_out;
				lo_alarm_reg <= lo_alarm_next;
				hi_alarm_reg <= hi_alarm_next;
			end else begin
				// unlatch clears between updates too
				lo_alarm_reg <= lo_alarm_reg && !i_alarm_dis && !i_alarm_unlatch;
				hi_alarm_reg <= hi_alarm_reg && !i_alarm_dis && !i_alarm_unlatch;
			end
		end
	end

	// --------------------------------------------------------------
	// echo and status at each update interval
	// --------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_echo <= aovc_pkg::VAL_RST;
			o_low_clamp_alarm <= 1'b0;
			o_high_clamp_alarm <= 1'b0;
			o_in_fault <= 1'b0;
			o_status_valid <= 1'b0;
		end else begin
			o_status_valid <= i_rpi_tick;
			if (i_rpi_tick) begin
				o_echo <= o_out;
				o_low_clamp_alarm <= lo_alarm_reg;
				o_high_clamp_alarm <= hi_alarm_reg;
				o_in_fault <= !is_run && !is_prog;
			end
		end
	end
endmodule // aovc_channel
`default_nettype wire

//--- bench/owner_model.sv
// owner model: controller-side update and interval strobes
// assumes: shares the module clock and its reset
`timescale 1ns/1ps
`default_nettype none
module owner_model (
	input wire logic i_mclk, // clock
	input wire logic i_rst_b, // sync reset, active low
	output logic o_update, // output update strobe
	output logic o_rpi_tick // update interval strobe
);
	logic [2:0] cnt_reg = 3'h0;
	always_ff @(posedge i_mclk) begin
		cnt_reg <= i_rst_b ? cnt_reg + 3'h1 : 3'h0;
	end
	// tick lands one cycle after every other update
	assign o_update = i_rst_b && (cnt_reg[1:0] == 2'h3);
	assign o_rpi_tick = i_rst_b && (cnt_reg == 3'h4);
endmodule // owner_model
`default_nettype wire

//--- bench/aovc_channel_properties.sv
// checker: port-level properties of one conditioner channel
// assumes: bound to aovc_channel, one clock domain
`timescale 1ns/1ps
`default_nettype none
module aovc_channel_checker (
	input wire logic i_mclk, // clock
	input wire logic i_rst_b, // reset
	input wire logic i_update, // update
	input wire logic i_rpi_tick, // interval
	input wire logic i_conn_ok, // link up
	input wire logic i_run_mode, // run
	input wire logic signed [31:0] i_data, // request
	input wire logic i_fault_mode, // user mode
	input wire logic signed [31:0] i_fault_value, // fault value
	input wire logic signed [31:0] i_clamp_hi, // high clamp
	input wire logic i_alarm_dis, // alarms off
	input wire logic i_ramp_run_en, // run ramp
	input wire logic i_ramp_on_fault_en, // fault ramp
	input wire logic signed [31:0] o_out, // output
	input wire logic signed [31:0] o_echo, // echo
	input wire logic o_high_clamp_alarm, // high alarm
	input wire logic o_in_fault, // fault flag
	input wire logic o_status_valid // refresh pulse
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	a_echo_applied: assert property (i_rpi_tick |=> o_echo == $past(o_out) && o_status_valid)
		else $error("echo differs from applied output");
	a_status_from_tick: assert property (o_status_valid |-> $past(i_rpi_tick))
		else $error("status refresh without interval tick");
	a_out_only_update: assert property (!i_update |=> $stable(o_out))
		else $error("output moved without update");
	a_clamp_high_out: assert property (i_update && i_run_mode && $past(i_run_mode) && i_conn_ok
		&& $past(i_conn_ok) && $past(i_rst_b) && !i_ramp_run_en && i_data > i_clamp_hi
		|=> o_out == $past(i_clamp_hi))
		else $error("high clamp not applied");
	a_high_alarm_set: assert property ((i_update && i_run_mode && $past(i_run_mode) && i_conn_ok
		&& $past(i_conn_ok) && $past(i_rst_b) && !i_alarm_dis && i_data > i_clamp_hi)
		##1 (i_rpi_tick && !i_alarm_dis) |=> o_high_clamp_alarm)
		else $error("high alarm missing");
	a_user_fault_val: assert property ($fell(i_conn_ok) && $past(i_rst_b) && i_fault_mode
		&& !i_ramp_on_fault_en ##1 !i_conn_ok ##1 (!i_conn_ok && i_update)
		|=> o_out == $past(i_fault_value))
		else $error("fault value not applied");
	a_hold_last_out: assert property (i_conn_ok ##1 (!i_conn_ok && !i_fault_mode)[*2]
		|=> $stable(o_out))
		else $error("held output moved");
	a_reconnect_clear: assert property (i_rpi_tick && i_conn_ok && $past(i_conn_ok)
		&& $past(i_conn_ok, 2) |=> !o_in_fault)
		else $error("fault flag after reconnect");
	cover property (i_update && i_data > i_clamp_hi);
	cover property ($fell(i_conn_ok));
	cover property (o_status_valid && o_high_clamp_alarm);
endmodule // aovc_channel_checker
bind aovc_channel aovc_channel_checker i_chk (.i_mclk, .i_rst_b, .i_update, .i_rpi_tick,
	.i_conn_ok, .i_run_mode, .i_data, .i_fault_mode, .i_fault_value, .i_clamp_hi, .i_alarm_dis,
	.i_ramp_run_en, .i_ramp_on_fault_en, .o_out, .o_echo, .o_high_clamp_alarm, .o_in_fault,
	.o_status_valid);
`default_nettype wire

//--- bench/tb.sv
// testbench: clamp, alarms, ramp and fault behaviour of one channel
// assumes: owner_model supplies update and interval strobes
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic upd, tick, conn = 1'b1, run = 1'b1, fmode = 1'b1, adis = 1'b0, lat = 1'b0, unl = 1'b0;
	logic ren = 1'b0, rfe = 1'b0, rpe = 1'b0, lo_al, hi_al, in_f, sv;
	logic signed [31:0] data = 32'h20, fval = 32'h55, pval = 32'h0, out, echo;
	logic [31:0] us = 32'hA, rate = 32'hF4240;
	int failures = 0, checks_done = 0;
	initial forever #10 i_mclk = ~i_mclk;
	owner_model i_own (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .o_update(upd), .o_rpi_tick(tick));
	aovc_channel i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_update(upd), .i_update_us(us),
		.i_rpi_tick(tick), .i_conn_ok(conn), .i_run_mode(run), .i_data(data),
		.i_prog_value(pval), .i_fault_mode(fmode), .i_fault_value(fval),
		.i_fault_dur(aovc_pkg::DUR_FOREVER), .i_final_value(32'h0), .i_clamp_hi(32'h100),
		.i_clamp_lo(32'hFFFFFF00), .i_alarm_dis(adis), .i_alarm_latch(lat), .i_alarm_unlatch(unl),
		.i_ramp_run_en(ren), .i_ramp_on_program_en(rpe), .i_ramp_on_fault_en(rfe),
		.i_ramp_rate(rate), .o_out(out), .o_echo(echo), .o_low_clamp_alarm(lo_al),
		.o_high_clamp_alarm(hi_al), .o_in_fault(in_f), .o_status_valid(sv));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task settle;
		repeat (24) @(posedge i_mclk);
		#1;
	endtask
	task wait_move(input logic [31:0] from);
		int n;
		n = 0;
		while (out === from && n < 40) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
	endtask
	task test_clamp;
		data = 32'h200;
		settle;
		chk(out, 32'h100);
		chk(echo, 32'h100);
		chk({30'h0, lo_al, hi_al}, 32'h1);
		data = 32'hFFFFFE00;
		settle;
		chk(out, 32'hFFFFFF00);
		chk({30'h0, lo_al, hi_al}, 32'h2);
		adis = 1'b1;
		settle;
		chk({30'h0, lo_al, hi_al}, 32'h0);
		adis = 1'b0;
		lat = 1'b1;
		data = 32'h200;
		settle;
		data = 32'h20;
		settle;
		chk({30'h0, lo_al, hi_al}, 32'h1);
		unl = 1'b1;
		@(posedge i_mclk) #1 unl = 1'b0;
		settle;
		chk({30'h0, lo_al, hi_al}, 32'h0);
		lat = 1'b0;
		$display("clamp test done");
	endtask
	task test_ramp;
		ren = 1'b1;
		data = 32'h64;
		wait_move(32'h20);
		chk(out, 32'h2A);
		settle;
		settle;
		chk(out, 32'h64);
		ren = 1'b0;
		$display("ramp test done");
	endtask
	task test_fault;
		conn = 1'b0;
		settle;
		chk(out, 32'h55);
		chk({31'h0, in_f}, 32'h1);
		conn = 1'b1;
		settle;
		chk(out, 32'h64);
		chk({31'h0, in_f}, 32'h0);
		rfe = 1'b1;
		conn = 1'b0;
		wait_move(32'h64);
		chk(out, 32'h5A);
		settle;
		chk(out, 32'h55);
		conn = 1'b1;
		rfe = 1'b0;
		settle;
		fmode = 1'b0;
		conn = 1'b0;
		// new request only once the loss has been taken
		@(posedge i_mclk);
		#1;
		data = 32'h30;
		settle;
		chk(out, 32'h64);
		conn = 1'b1;
		settle;
		chk(out, 32'h30);
		$display("fault test done");
	endtask
	task test_program;
		pval = 32'h40;
		rpe = 1'b1;
		run = 1'b0;
		wait_move(32'h30);
		chk(out, 32'h3A);
		settle;
		chk(out, 32'h40);
		run = 1'b1;
		rpe = 1'b0;
		settle;
		chk(out, 32'h30);
		$display("program test done");
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge i_mclk);
		failures++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge i_mclk);
		#1 i_rst_b = 1'b1;
		settle;
		test_clamp;
		test_ramp;
		test_fault;
		test_program;
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
